//--- core/adc_pin_sync.sv
// Two-flop synchroniser for the link input pins
`default_nettype none
module adc_pin_sync #(
   parameter int unsigned WIDTH = 3
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [WIDTH-1:0] pins_async,
   output logic      [WIDTH-1:0] pins_sync
);
   logic [WIDTH-1:0] meta_r;

   initial begin
      if (WIDTH < 1) begin
         $error("adc_pin_sync needs WIDTH >= 1");
      end
   end

   // First stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_r    <= '0;
         pins_sync <= '0;
      end else begin
         meta_r    <= pins_async;
         pins_sync <= meta_r;
      end
   end
endmodule : adc_pin_sync
`default_nettype wire

//--- core/adc_serial_ctrl.sv
// Converter interface-mode, conversion and serial readout control with AHB-Lite registers
// Function
// - Interface mode is sampled from serial input at convert-start rising edge.
// - Serial input high selects select mode; low selects daisy-chain mode.
// - Serial input tied to convert-start always resolves to daisy-chain mode.
// - An optional start bit may precede result bits in both modes.
// - Start bit serves as busy indicator, host may use as interrupt.
// - Select mode enables busy if start or serial input low at conversion end.
// - Chain mode enables busy if shift clock high at convert-start rising edge.
// - Core powers down automatically after every conversion phase.
// - Three-wire select uses start, shift clock, output; serial input held high.
// - Four-wire select uses serial input as separate readback select.
// - Chain mode passes serial input data through to output like shift register.
// - Convert-start rising edge begins conversion; no shift clock needed meanwhile.
// - Overrange saturates to all ones, underrange to all zeros.
// - After MSB, each further bit shifts out on shift clock falling edges.
`default_nettype none
module adc_serial_ctrl
   import adc_serial_pkg::*;
#(
   parameter int unsigned CONV_CYC = CONV_CYCLES
) (
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic      [31:0]               hrdata,
   output logic                           hreadyout,
   output logic      [1:0]                hresp,
   input  wire logic                      convert_start,
   input  wire logic                      serial_in_select,
   input  wire logic                      shift_clk,
   output adc_serial_pkg::link_out_s      link_out,
   output logic                           core_powered,
   output logic                           irq
);
   import adc_serial_pkg::*;

   // Counter width bounds the conversion length
   initial begin
      if (CONV_CYC < 1 || CONV_CYC > 65535) begin
         $error("CONV_CYC out of range");
      end
   end

   // Pin samples, sequencer state and latched link settings
   link_in_s    pin_s;
   link_in_s    pin_d_r;
   conv_state_e state_r;
   if_mode_e    mode_r;
   logic        busy_en_r;
   logic [15:0] cnt_r;
   logic [16:0] shreg_r;
   logic [4:0]  bits_left_r;
   logic        out_bit_r;
   logic        drive_r;
   logic [15:0] sample_r;
   logic        ovr_r;
   logic        und_r;
   logic [15:0] result_r;
   logic [IRQ_BITS-1:0] irq_stat_r;
   logic [IRQ_BITS-1:0] irq_mask_r;
   // Bus address phase held over into the data phase
   logic        ap_valid_r;
   logic        ap_write_r;
   logic [7:0]  ap_addr_r;
   // Combinational helpers
   logic        cs_rise;
   logic        sck_fall;
   logic        conv_done;
   logic        read_done;
   logic [15:0] code_w;
   logic        sel_active;
   logic        busy_now;
   logic [IRQ_BITS-1:0] irq_evt;

   adc_pin_sync #(
      .WIDTH      (3)
   ) u_sync (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .pins_async ({convert_start, serial_in_select, shift_clk}),
      .pins_sync  (pin_s)
   );

   // Edge detection on synchronised pins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_d_r <= '0;
      end else begin
         pin_d_r <= pin_s;
      end
   end

   assign cs_rise   = pin_s.convert_start & ~pin_d_r.convert_start;
   assign sck_fall  = ~pin_s.shift_clk & pin_d_r.shift_clk;
   assign conv_done = (state_r == ST_CONVERT) && (cnt_r == 16'(CONV_CYC - 1));

   // Saturated straight binary code
   always_comb begin
      if (ovr_r) begin
         code_w = CODE_FULL;
      end else if (und_r) begin
         code_w = CODE_ZERO;
      end else begin
         code_w = sample_r;
      end
   end

   // Busy decision as it will stand once the conversion ends
   // Needed a cycle early so the readout length matches the start bit
   assign busy_now = (mode_r == MODE_SELECT) ? (~pin_s.convert_start | ~pin_s.serial_in_select) : busy_en_r;

   // Mode latched only at start edge; pin samples are pre-edge values
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_r <= MODE_SELECT;
      end else if (cs_rise) begin
         // Tied pins: previous serial input level was low, so chain mode
         mode_r <= pin_d_r.serial_in_select ? MODE_SELECT : MODE_CHAIN;
      end
   end

   // Busy start bit: chain decides at start edge, select at conversion end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_en_r <= 1'b0;
      end else if (cs_rise) begin
         busy_en_r <= ~pin_d_r.serial_in_select & pin_d_r.shift_clk;
      end else if (conv_done) begin
         busy_en_r <= busy_now;
      end
   end

   // Select-mode readout gate: start low (3-wire) or serial input low (4-wire)
   assign sel_active = ~pin_s.convert_start | ~pin_s.serial_in_select;

   // Conversion sequencer and serial shifter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r     <= ST_ACQUIRE;
         cnt_r       <= '0;
         shreg_r     <= '0;
         bits_left_r <= '0;
         result_r    <= '0;
      end else begin
         unique case (state_r)
            ST_ACQUIRE: begin
               if (cs_rise) begin
                  state_r <= ST_CONVERT;
                  cnt_r   <= '0;
               end
            end
            ST_CONVERT: begin
               // Own clock paces the conversion; shift clock not needed
               cnt_r <= cnt_r + 16'd1;
               if (conv_done) begin
                  state_r  <= ST_READOUT;
                  result_r <= code_w;
                  // Start bit is a leading zero ahead of the MSB
                  shreg_r  <= {1'b0, code_w};
                  // Busy start bit adds one falling edge to the readout
                  bits_left_r <= 5'(RESULT_BITS) + 5'(busy_now);
               end
            end
            ST_READOUT: begin
               // A new start edge abandons an unfinished readout
               if (cs_rise) begin
                  state_r <= ST_CONVERT;
                  cnt_r   <= '0;
               end else if (sck_fall && bits_left_r != 5'd0) begin
                  // Chain: shift serial input in at the bottom
                  shreg_r <= {shreg_r[15:0],
                              (mode_r == MODE_CHAIN) ? pin_s.serial_in_select : 1'b0};
                  if (mode_r == MODE_SELECT) begin
                     bits_left_r <= bits_left_r - 5'd1;
                  end
               end
            end
            default: begin
               state_r <= ST_ACQUIRE;
            end
         endcase
      end
   end

   assign read_done = (state_r == ST_READOUT) && sck_fall && (bits_left_r == 5'd1)
                      && (mode_r == MODE_SELECT);

   // Output bit; busy start bit selects where the MSB sits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_bit_r <= 1'b0;
      end else if (state_r == ST_READOUT) begin
         out_bit_r <= busy_en_r ? shreg_r[16] : shreg_r[15];
      end else begin
         out_bit_r <= 1'b0;
      end
   end

   // Output enable: chain drives all readout, select while chosen and bits remain
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         drive_r <= 1'b0;
      end else if (state_r == ST_READOUT) begin
         drive_r <= (mode_r == MODE_CHAIN) || (sel_active && bits_left_r != 5'd0);
      end else begin
         // Idle with start and serial input low shows a driven low
         drive_r <= (state_r == ST_ACQUIRE) && ~pin_s.convert_start && ~pin_s.serial_in_select;
      end
   end

   // Pin outputs and power indicator
   assign link_out.serial_result_out  = out_bit_r;
   assign link_out.serial_result_oe_n = ~drive_r;
   assign core_powered                = (state_r == ST_CONVERT);

   // Interrupt events: conversion done, readout finished
   assign irq_evt = {read_done, conv_done};

   // AHB-Lite address phase capture
   // Write data arrive a cycle after the address, so the decode is kept
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_r <= 1'b0;
         ap_write_r <= 1'b0;
         ap_addr_r  <= '0;
      end else if (hready) begin
         ap_valid_r <= hsel && htrans == HTRANS_NONSEQ;
         ap_write_r <= hwrite;
         ap_addr_r  <= haddr[7:0];
      end
   end

   // Writable registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sample_r   <= '0;
         ovr_r      <= 1'b0;
         und_r      <= 1'b0;
         irq_mask_r <= '0;
      end else if (ap_valid_r && ap_write_r) begin
         if (ap_addr_r == OFS_SAMPLE) begin
            sample_r <= hwdata[15:0];
            ovr_r    <= hwdata[CTRL_OVR_BIT];
            und_r    <= hwdata[CTRL_UND_BIT];
         end
         if (ap_addr_r == OFS_IRQ_MASK) begin
            irq_mask_r <= hwdata[IRQ_BITS-1:0];
         end
      end
   end

   // Sticky status, set wins over write-one clear
   // An event in the cycle of a clear is kept, so none is lost
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_r <= '0;
      end else begin
         for (int i = 0; i < IRQ_BITS; i++) begin
            if (irq_evt[i]) begin
               irq_stat_r[i] <= 1'b1;
            end else if (ap_valid_r && ap_write_r && ap_addr_r == OFS_IRQ_STAT && hwdata[i]) begin
               irq_stat_r[i] <= 1'b0;
            end
         end
      end
   end

   // Read data registered at address phase
   // Holds steady through the whole data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= WORD_ZERO;
      end else if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
         unique case (haddr[7:0])
            OFS_CTRL:     hrdata <= {30'd0, busy_en_r, mode_r};
            OFS_SAMPLE:   hrdata <= {14'd0, und_r, ovr_r, sample_r};
            OFS_STATUS:   hrdata <= {30'd0, state_r};
            OFS_IRQ_STAT: hrdata <= {30'd0, irq_stat_r};
            OFS_IRQ_MASK: hrdata <= {30'd0, irq_mask_r};
            OFS_RESULT:   hrdata <= {16'd0, result_r};
            default:      hrdata <= WORD_ZERO;
         endcase
      end
   end

   // Zero wait states, always OKAY; interrupt is a level
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;
   assign irq       = |(irq_stat_r & irq_mask_r);
endmodule : adc_serial_ctrl
`default_nettype wire

//--- core/adc_serial_pkg.sv
// Package: constants, states and carrier structs for the converter serial interface
`default_nettype none
package adc_serial_pkg;
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned CONV_TIME_NS    = 2_200;
   localparam int unsigned CONV_CYCLES     = (CONV_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
   localparam int unsigned RESULT_BITS     = 16;
   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_SAMPLE      = 8'h04;
   localparam logic [7:0]  OFS_STATUS      = 8'h08;
   localparam logic [7:0]  OFS_IRQ_STAT    = 8'h0C;
   localparam logic [7:0]  OFS_IRQ_MASK    = 8'h10;
   localparam logic [7:0]  OFS_RESULT      = 8'h14;
   // Field positions
   localparam int unsigned CTRL_OVR_BIT    = 16;
   localparam int unsigned CTRL_UND_BIT    = 17;
   localparam int unsigned IRQ_CONV_BIT    = 0;
   localparam int unsigned IRQ_READ_BIT    = 1;
   localparam int unsigned IRQ_BITS        = 2;
   localparam logic [15:0] CODE_ZERO       = 16'h0000;
   localparam logic [15:0] CODE_FULL       = 16'hFFFF;
   localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'b10;
   localparam logic [1:0]  HRESP_OKAY      = 2'b00;

   typedef enum logic [1:0] {
      ST_ACQUIRE = 2'b00,
      ST_CONVERT = 2'b01,
      ST_READOUT = 2'b10
   } conv_state_e;

   typedef enum logic {
      MODE_CHAIN  = 1'b0,
      MODE_SELECT = 1'b1
   } if_mode_e;

   // Synchronised link pins
   typedef struct packed {
      logic convert_start;
      logic serial_in_select;
      logic shift_clk;
   } link_in_s;

   // Link output pin pair, oe low while driven
   typedef struct packed {
      logic serial_result_out;
      logic serial_result_oe_n;
   } link_out_s;
endpackage : adc_serial_pkg
`default_nettype wire

//--- testbench/adc_host_model.sv
// Host link model: shift clock frames and result capture
`default_nettype none
module adc_host_model (
   input  wire logic        sck_idle,
   input  wire logic        req,
   input  wire logic [4:0]  nbits,
   input  wire logic        sdo_wire,
   output logic             shift_clk,
   output logic             done,
   output logic [20:0]      rx
);
   timeunit 1ns;
   timeprecision 1ns;
   logic frm;
   logic sck_r;
   // Clock stands at its idle level outside frames
   assign shift_clk = frm ? sck_r : sck_idle;
   // One frame per request, 400 ns period, capture on rise
   initial begin
      frm = 1'b0;
      sck_r = 1'b0;
      done = 1'b0;
      rx = '0;
      forever begin
         wait (req);
         #10;
         rx = '0;
         frm = 1'b1;
         for (int i = 0; i < nbits; i++) begin
            #200 sck_r = 1'b1;
            rx = {rx[19:0], sdo_wire};
            #200 sck_r = 1'b0;
         end
         frm = 1'b0;
         done = 1'b1;
         wait (!req);
         done = 1'b0;
      end
   end
endmodule : adc_host_model
`default_nettype wire

//--- testbench/adc_serial_chk.sv
// Checker for converter control port timing
`default_nettype none
module adc_serial_chk
   import adc_serial_pkg::*;
#(
   parameter int unsigned CONV_CYC = CONV_CYCLES
) (
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hreadyout,
   input  wire logic [1:0]            hresp,
   input  wire logic                  convert_start,
   input  wire logic                  serial_in_select,
   input  wire logic                  shift_clk,
   input  wire adc_serial_pkg::link_out_s link_out,
   input  wire logic                  core_powered,
   input  wire logic                  irq
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int CMAX = CONV_CYC + 4;
   logic [7:0] run_r;
   logic [3:0] quiet_r;
   logic [2:0] pins_r;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Length of the running conversion
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_r <= 8'h00;
      end else begin
         run_r <= core_powered ? run_r + 8'h01 : 8'h00;
      end
   end
   // Cycles since a pin moved or a conversion ran
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pins_r <= 3'h0;
         quiet_r <= 4'h0;
      end else begin
         pins_r <= {convert_start, serial_in_select, shift_clk};
         if (core_powered || pins_r != {convert_start, serial_in_select, shift_clk}) begin
            quiet_r <= 4'h0;
         end else if (quiet_r != 4'hF) begin
            quiet_r <= quiet_r + 4'h1;
         end
      end
   end
   sequence s_start;
      $rose(convert_start);
   endsequence
   sequence s_conv_run;
      core_powered ##1 core_powered;
   endsequence
   ready_const_a: assert property (hreadyout) else $error("hreadyout low");
   resp_okay_a: assert property (hresp == HRESP_OKAY) else $error("hresp not okay");
   conv_start_a: assert property (s_start |-> ##[1:6] core_powered) else $error("no conversion");
   conv_end_a: assert property ($rose(core_powered) |-> ##[1:CMAX] !core_powered) else $error("no power down");
   conv_len_a: assert property ($fell(core_powered) |-> run_r == CONV_CYC) else $error("conversion length");
   hiz_conv_a: assert property (s_conv_run |-> link_out.serial_result_oe_n) else $error("driven in conversion");
   shift_only_a: assert property ($changed(link_out.serial_result_out) && !link_out.serial_result_oe_n
      && !$past(link_out.serial_result_oe_n) |-> quiet_r < 4'h6) else $error("unprompted bit");
   rst_idle_a: assert property ($rose(hresetn) |-> link_out.serial_result_oe_n && !irq && !core_powered)
      else $error("bad idle after reset");
endmodule : adc_serial_chk
bind adc_serial_ctrl adc_serial_chk #(.CONV_CYC(CONV_CYC)) i_adc_serial_chk (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .convert_start(convert_start), .serial_in_select(serial_in_select),
   .shift_clk(shift_clk), .link_out(link_out), .core_powered(core_powered), .irq(irq));
`default_nettype wire

//--- testbench/adc_serial_ctrl_tb_top.sv
// Testbench: register and link scenarios for the converter control block
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fail_count++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module adc_serial_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import adc_serial_pkg::*;
   localparam int unsigned CC = 4;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, irq, core_powered;
   logic        convert_start, serial_in_select, sck_idle, shift_clk, req, done;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans, hresp;
   logic [2:0]  hsize;
   logic [4:0]  nbits;
   logic [20:0] rx;
   link_out_s   link_out;
   wire logic   sdo_wire = link_out.serial_result_oe_n ? 1'b1 : link_out.serial_result_out;
   int          fail_count = 0;
   int          n_compared = 0;
   // Columns: si, sck, hold cs, hold si, tied, read cs, read si, extra shifts
   logic [7:0]  cfg   [6] = '{8'hB2, 8'h92, 8'hA4, 8'h25, 8'h64, 8'h3E};
   logic [31:0] samp  [6] = '{32'h0000_A5C3, 32'h0001_1234, 32'h0002_8000, 32'h0000_8001, 32'h0000_7FFF,
                              32'h0000_0001};
   logic [15:0] ecode [6] = '{16'hA5C3, 16'hFFFF, 16'h0000, 16'h8001, 16'h7FFF, 16'h0001};
   logic [1:0]  ectl  [6] = '{2'h1, 2'h3, 2'h3, 2'h0, 2'h2, 2'h0};
   logic [7:0]  rofs  [6] = '{OFS_CTRL, OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_RESULT, 8'h20};
   adc_serial_ctrl #(.CONV_CYC(CC)) i_adc_serial_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .convert_start(convert_start),
      .serial_in_select(serial_in_select), .shift_clk(shift_clk), .link_out(link_out),
      .core_powered(core_powered), .irq(irq));
   adc_host_model i_adc_host_model (.sck_idle(sck_idle), .req(req), .nbits(nbits), .sdo_wire(sdo_wire),
      .shift_clk(shift_clk), .done(done), .rx(rx));
   // Bus clock
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask : xfer
   task automatic run_case(input int i);
      logic [7:0] c;
      c = cfg[i];
      xfer(1'b1, OFS_IRQ_MASK, (i == 0) ? WORD_ZERO : 32'h0000_0003);
      xfer(1'b1, OFS_SAMPLE, samp[i]);
      xfer(1'b0, OFS_SAMPLE, WORD_ZERO);
      `CHK("sample", samp[i], q)
      serial_in_select <= c[7];
      sck_idle <= c[6];
      repeat (4) @(posedge hclk);
      convert_start <= 1'b1;
      serial_in_select <= c[7] | c[3];
      repeat (4) @(posedge hclk);
      convert_start <= c[5];
      serial_in_select <= c[4];
      sck_idle <= 1'b0;
      repeat (CC + 8) @(posedge hclk);
      `CHK("powered", 1'b0, core_powered)
      xfer(1'b0, OFS_CTRL, WORD_ZERO);
      `CHK("ctrl", {30'h0, ectl[i]}, q)
      xfer(1'b0, OFS_RESULT, WORD_ZERO);
      `CHK("result", {16'h0000, ecode[i]}, q)
      convert_start <= c[2];
      serial_in_select <= c[1];
      nbits <= 5'h10 + ectl[i][1] + (c[0] ? 5'h04 : 5'h00);
      repeat (6) @(posedge hclk);
      req <= 1'b1;
      while (done !== 1'b1) @(posedge hclk);
      req <= 1'b0;
      `CHK("frame", {5'h00, ecode[i]} << (c[0] ? 4 : 0), rx)
      repeat (4) @(posedge hclk);
      `CHK("released", ectl[i][0], link_out.serial_result_oe_n)
      xfer(1'b0, OFS_IRQ_STAT, WORD_ZERO);
      `CHK("conv_done", 1'b1, q[IRQ_CONV_BIT])
      `CHK("read_done", ectl[i][0], q[IRQ_READ_BIT])
      `CHK("irq", (i != 0), irq)
      xfer(1'b1, OFS_IRQ_STAT, 32'h0000_0003);
      xfer(1'b0, OFS_IRQ_STAT, WORD_ZERO);
      `CHK("irq_clr", 1'b0, irq)
      convert_start <= 1'b0;
      serial_in_select <= 1'b0;
   endtask : run_case
   task automatic wrap_up;
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up
   // Main sequence: reset values, refused accesses, then every mode case
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      {convert_start, serial_in_select, sck_idle, req, nbits} = '0;
      hsize = 3'h2;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int k = 0; k < 6; k++) begin
         xfer(1'b0, rofs[k], WORD_ZERO);
         `CHK("reset_value", (k == 0) ? 32'h0000_0001 : WORD_ZERO, q)
      end
      xfer(1'b1, OFS_CTRL, 32'hFFFF_FFFF);
      xfer(1'b1, 8'h20, 32'hFFFF_FFFF);
      xfer(1'b0, 8'h20, WORD_ZERO);
      `CHK("unmapped", WORD_ZERO, q)
      xfer(1'b0, OFS_CTRL, WORD_ZERO);
      `CHK("ctrl_ro", 32'h0000_0001, q)
      for (int i = 0; i < 6; i++) begin
         run_case(i);
      end
      wrap_up();
   end
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge hclk);
      fail_count++;
      wrap_up();
   end
endmodule : adc_serial_ctrl_tb_top
`default_nettype wire
